//--- hdl/stall_prevention_supervisor.sv
// stall prevention supervisor with its AXI4-Lite register file
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module stall_prevention_supervisor #(
	parameter int unsigned TICK_CYCLES = stall_pkg::TICK_CYCLES,
	parameter int unsigned NUM_VIN     = 4  // virtual input channels
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	// AXI4-Lite slave
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	// measurement and operating state, same clock domain
	input  wire logic [15:0] i_out_current,   // % rated drive, 0.1 %
	input  wire logic [15:0] i_torque_current, // % motor torque, 0.1 %
	input  wire logic [15:0] i_out_freq,       // 0.01 Hz
	input  wire logic        i_accel,
	input  wire logic        i_const_speed,
	input  wire logic        i_decel,
	input  wire logic        i_regen,          // regenerating
	input  wire logic        i_fast_limit_hit, // fast limit acting
	input  wire logic        i_regen_avoid,
	input  wire logic        i_ov_stall,
	input  wire logic [NUM_VIN-1:0] i_virtual_in,
	// drive-side outputs
	output logic             o_stall_engage,
	output logic             o_fast_limit_enable,
	output logic             o_freq_raise,
	output logic [15:0]      o_freq_ceiling,
	output logic             o_stall_active_flag,
	output logic             o_open_collector_output,
	output logic [1:0]       o_virtual_out,
	output logic             o_stall_stop_fault,
	output logic             o_output_shutoff,
	output logic             o_irq
);
	typedef struct packed {
		// bus side
		logic        awready;
		logic        wready;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  waddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		stall_pkg::rd_state_e rd;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		// settings
		logic        torque_mode;
		logic [15:0] base_level;
		logic [15:0] hs_factor;
		logic [15:0] second_level;
		logic [15:0] red_start;
		logic [7:0]  action_sel;
		logic [15:0] flag_delay;
		logic [15:0] max_freq;
		logic [23:0] out_func;
		logic [31:0] in_func;
		logic [1:0]  irq_stat;
		logic [1:0]  irq_mask;
		// timing and flags
		logic [23:0] prescale;
		logic        raw_d;
		logic [3:0]  hold_cnt;
		logic [7:0]  delay_cnt;
		logic [5:0]  stop_cnt;
		logic        engage;
		logic        fast_en;
		logic        freq_raise;
		logic        flag;
		logic        fault;
		logic        oc_out;
		logic [1:0]  vout;
		logic        irq;
	} sup_s;

	sup_s q;                 // all state
	sup_s next_q;            // next value of all state
	stall_level_if lif ();   // link to the level calculator

	logic        tick;       // one pulse per 100ms
	logic        second_set; // second level requested
	logic [15:0] base_sel;   // level before reduction
	logic [15:0] measure;    // current or torque current
	logic        driving;
	logic        dis_fast;   // decoded select bits
	logic        dis_acc;
	logic        dis_const;
	logic        dis_dec;
	logic        stop_opt;
	logic        state_ok;   // stall prevention allowed now
	logic        raw;        // flag source before hold and delay
	logic        hold_flag;  // source stretched to its least time
	logic        do_wr;
	logic [31:0] wmask;
	logic [31:0] wval;

	stall_level_calc u_calc (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.lif        (lif.calc)
	);

	// byte-lane mask from the write strobes
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{q.wstrb[i]}};
		end
	end

	// decode of the select code and of the level inputs
	always_comb begin
		second_set = 1'b0;
		for (int i = 0; i < NUM_VIN; i++) begin
			if (q.in_func[i*8 +: 8] == stall_pkg::FUNC_POS &&
				i_virtual_in[i]) begin
				second_set = 1'b1;
			end
		end
		base_sel = q.base_level;
		if (second_set && q.second_level != stall_pkg::SENTINEL) begin
			base_sel = q.second_level;
		end
		// with equal capacities the torque current percent is already
		// the rated torque reference, so the level compares directly
		measure = q.torque_mode ? i_torque_current : i_out_current;
		driving = !i_regen;
		dis_fast  = q.action_sel[0];
		dis_acc   = q.action_sel[1];
		dis_const = q.action_sel[2];
		dis_dec   = q.action_sel[3];
		stop_opt  = q.action_sel[4];
		if (q.action_sel == stall_pkg::SEL_SPLIT ||
			q.action_sel == stall_pkg::SEL_SPLIT_NF) begin
			// split settings: active when driving, off when regenerating; 101 keeps the fast limit off throughout
			dis_fast  = !driving ||
				q.action_sel == stall_pkg::SEL_SPLIT_NF;
			dis_acc   = !driving;
			dis_const = !driving;
			dis_dec   = !driving;
			stop_opt  = 1'b0;
		end else if (q.action_sel > 8'h1F) begin
			// out-of-range codes fall back to all states and the fast limit enabled, stop option off
			dis_fast  = 1'b0;
			dis_acc   = 1'b0;
			dis_const = 1'b0;
			dis_dec   = 1'b0;
			stop_opt  = 1'b0;
		end
		state_ok = (i_accel && !dis_acc) || (i_const_speed && !dis_const) ||
			(i_decel && !dis_dec);
		if (q.torque_mode && i_decel && i_out_freq <= stall_pkg::FREQ_DEC_TQ)
		begin
			state_ok = 1'b0;
		end
		// fast limit alone is not a source of the flag
		raw = q.engage || i_regen_avoid || i_ov_stall;
		hold_flag = raw || (q.hold_cnt != 4'h0);
		tick = (q.prescale == 24'(TICK_CYCLES - 1));
		do_wr = q.aw_got && q.w_got && !q.bvalid;
		wval = (q.wdata & wmask);
	end

	// one next-state process for bus, registers and supervision
	always_comb begin
		next_q = q;
		next_q.prescale = tick ? 24'h0 : q.prescale + 24'h1;
		// write address and data taken in either order
		if (i_awvalid && q.awready) begin
			next_q.aw_got = 1'b1;
			next_q.waddr  = i_awaddr;
		end
		if (i_wvalid && q.wready) begin
			next_q.w_got = 1'b1;
			next_q.wdata = i_wdata;
			next_q.wstrb = i_wstrb;
		end
		if (q.bvalid && i_bready) begin
			next_q.bvalid = 1'b0;
		end
		if (do_wr) begin
			next_q.aw_got = 1'b0;
			next_q.w_got  = 1'b0;
			next_q.bvalid = 1'b1;
			next_q.bresp  = stall_pkg::RESP_OKAY;
			case (q.waddr)
			stall_pkg::A_CTRL: begin
				if (q.wstrb[0]) begin
					next_q.torque_mode = q.wdata[stall_pkg::CTRL_TORQUE];
				end
			end
			stall_pkg::A_BASE_LVL: begin
				next_q.base_level = (q.base_level & ~wmask[15:0]) | wval[15:0];
			end
			stall_pkg::A_HS_FACTOR: begin
				next_q.hs_factor = (q.hs_factor & ~wmask[15:0]) | wval[15:0];
			end
			stall_pkg::A_SECOND_LVL: begin
				next_q.second_level = (q.second_level & ~wmask[15:0]) |
					wval[15:0];
			end
			stall_pkg::A_RED_START: begin
				next_q.red_start = (q.red_start & ~wmask[15:0]) | wval[15:0];
			end
			stall_pkg::A_ACTION_SEL: begin
				next_q.action_sel = (q.action_sel & ~wmask[7:0]) | wval[7:0];
			end
			stall_pkg::A_FLAG_DELAY: begin
				next_q.flag_delay = (q.flag_delay & ~wmask[15:0]) | wval[15:0];
			end
			stall_pkg::A_MAX_FREQ: begin
				next_q.max_freq = (q.max_freq & ~wmask[15:0]) | wval[15:0];
			end
			stall_pkg::A_OUT_FUNC: begin
				next_q.out_func = (q.out_func & ~wmask[23:0]) | wval[23:0];
			end
			stall_pkg::A_IN_FUNC: begin
				next_q.in_func = (q.in_func & ~wmask) | wval;
			end
			stall_pkg::A_IRQ_STAT: begin
				next_q.irq_stat = q.irq_stat & ~wval[1:0]; // write one clears
			end
			stall_pkg::A_IRQ_MASK: begin
				next_q.irq_mask = (q.irq_mask & ~wmask[1:0]) | wval[1:0];
			end
			stall_pkg::A_STATUS: begin
				next_q.bresp = stall_pkg::RESP_OKAY; // read-only, ignored
			end
			default: begin
				next_q.bresp = stall_pkg::RESP_SLVERR;
			end
			endcase
		end
		next_q.awready = !next_q.aw_got && !next_q.bvalid;
		next_q.wready  = !next_q.w_got && !next_q.bvalid;
		// read channel: answer one cycle after the address is taken
		case (q.rd)
		stall_pkg::RD_IDLE: begin
			if (i_arvalid && q.arready) begin
				next_q.rd      = stall_pkg::RD_VALID;
				next_q.arready = 1'b0;
				next_q.rresp   = stall_pkg::RESP_OKAY;
				case (i_araddr)
				stall_pkg::A_CTRL:       next_q.rdata = {31'h0, q.torque_mode};
				stall_pkg::A_BASE_LVL:   next_q.rdata = {16'h0, q.base_level};
				stall_pkg::A_HS_FACTOR:  next_q.rdata = {16'h0, q.hs_factor};
				stall_pkg::A_SECOND_LVL: next_q.rdata = {16'h0, q.second_level};
				stall_pkg::A_RED_START:  next_q.rdata = {16'h0, q.red_start};
				stall_pkg::A_ACTION_SEL: next_q.rdata = {24'h0, q.action_sel};
				stall_pkg::A_FLAG_DELAY: next_q.rdata = {16'h0, q.flag_delay};
				stall_pkg::A_MAX_FREQ:   next_q.rdata = {16'h0, q.max_freq};
				stall_pkg::A_OUT_FUNC:   next_q.rdata = {8'h0, q.out_func};
				stall_pkg::A_IN_FUNC:    next_q.rdata = q.in_func;
				stall_pkg::A_STATUS: begin
					next_q.rdata = {lif.level, 11'h0, second_set,
						q.fault, q.flag, hold_flag, q.engage};
				end
				stall_pkg::A_IRQ_STAT:   next_q.rdata = {30'h0, q.irq_stat};
				stall_pkg::A_IRQ_MASK:   next_q.rdata = {30'h0, q.irq_mask};
				default: begin
					next_q.rdata = 32'h0;
					next_q.rresp = stall_pkg::RESP_SLVERR;
				end
				endcase
			end
		end
		stall_pkg::RD_VALID: begin
			if (i_rready) begin
				next_q.rd      = stall_pkg::RD_IDLE;
				next_q.arready = 1'b1;
			end
		end
		default: begin
			next_q.rd      = stall_pkg::RD_IDLE;
			next_q.arready = 1'b1;
		end
		endcase

		// stall prevention engages above a nonzero level
		next_q.engage = (lif.level != 16'h0) && (measure > lif.level) &&
			state_ok && !q.fault;
		next_q.fast_en = !dis_fast && !q.fault;
		next_q.freq_raise = q.engage && q.torque_mode && i_regen;
		// least flag time: hold counted in whole ticks, rounded up
		next_q.raw_d = raw;
		if (raw && !q.raw_d) begin
			next_q.hold_cnt = 4'(stall_pkg::HOLD_TICKS + 1);
		end else if (tick && q.hold_cnt != 4'h0) begin
			next_q.hold_cnt = q.hold_cnt - 4'h1;
		end
		// output delay in 0.1s ticks; first partial tick adds margin
		if (!hold_flag) begin
			next_q.delay_cnt = 8'h0;
		end else if (tick && q.delay_cnt != 8'hFF) begin
			next_q.delay_cnt = q.delay_cnt + 8'h1;
		end
		if (q.flag_delay == stall_pkg::SENTINEL) begin
			next_q.flag = 1'b0;
		end else if (q.flag_delay == 16'h0) begin
			next_q.flag = hold_flag;
		end else begin
			next_q.flag = hold_flag &&
				(16'(q.delay_cnt) > q.flag_delay);
		end
		// frequency pinned at 1Hz by stall prevention
		if (!(q.engage && i_out_freq <= stall_pkg::FREQ_PIN_LOW)) begin
			next_q.stop_cnt = 6'h0;
		end else if (tick && q.stop_cnt != 6'h3F) begin
			next_q.stop_cnt = q.stop_cnt + 6'h1;
		end
		// fault clear first, so that a new cause overrides it
		if (do_wr && q.waddr == stall_pkg::A_CTRL && q.wstrb[0] &&
			q.wdata[stall_pkg::CTRL_FCLR]) begin
			next_q.fault = 1'b0;
		end
		if (q.stop_cnt > 6'(stall_pkg::STOP_TICKS)) begin
			next_q.fault = 1'b1;
		end
		if (stop_opt && q.flag) begin
			next_q.fault = 1'b1;
		end
		// function routing of the flag
		next_q.oc_out = (q.out_func[7:0] == stall_pkg::FUNC_POS && q.flag) ||
			(q.out_func[7:0] == stall_pkg::FUNC_NEG && !q.flag);
		for (int i = 0; i < 2; i++) begin
			next_q.vout[i] = (q.out_func[(i+1)*8 +: 8] == stall_pkg::FUNC_POS &&
				q.flag) || (q.out_func[(i+1)*8 +: 8] == stall_pkg::FUNC_NEG &&
				!q.flag);
		end
		// events set over a same-cycle clear
		if (next_q.flag && !q.flag) begin
			next_q.irq_stat[stall_pkg::IRQ_FLAG] = 1'b1;
		end
		if (next_q.fault && !q.fault) begin
			next_q.irq_stat[stall_pkg::IRQ_FAULT] = 1'b1;
		end
		next_q.irq = |(next_q.irq_stat & next_q.irq_mask);
	end

	// single state register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			q              <= '0;
			q.awready      <= 1'b1;
			q.wready       <= 1'b1;
			q.arready      <= 1'b1;
			q.rd           <= stall_pkg::RD_IDLE;
			q.base_level   <= stall_pkg::RST_BASE_LVL;
			q.hs_factor    <= stall_pkg::SENTINEL;
			q.second_level <= stall_pkg::SENTINEL;
			q.red_start    <= stall_pkg::RST_RED_START;
			q.max_freq     <= stall_pkg::RST_MAX_FREQ;
			q.fast_en      <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	// feed the level calculator
	assign lif.base_level = base_sel;
	assign lif.factor     = q.hs_factor;
	assign lif.start_freq = q.red_start;
	assign lif.out_freq   = i_out_freq;

	// outputs straight from state
	assign o_awready = q.awready;
	assign o_wready  = q.wready;
	assign o_bresp   = q.bresp;
	assign o_bvalid  = q.bvalid;
	assign o_arready = q.arready;
	assign o_rdata   = q.rdata;
	assign o_rresp   = q.rresp;
	assign o_rvalid  = (q.rd == stall_pkg::RD_VALID);
	assign o_stall_engage          = q.engage;
	assign o_fast_limit_enable     = q.fast_en;
	assign o_freq_raise            = q.freq_raise;
	assign o_freq_ceiling          = q.max_freq;
	assign o_stall_active_flag     = q.flag;
	assign o_open_collector_output = q.oc_out;
	assign o_virtual_out           = q.vout;
	assign o_stall_stop_fault      = q.fault;
	assign o_output_shutoff        = q.fault;
	assign o_irq                   = q.irq;
endmodule // stall_prevention_supervisor

//--- include/stall_pkg.sv
// constants, register map and field layout of the stall supervisor
package stall_pkg;
	// clock and time base
	localparam int unsigned CLK_MHZ      = 125;     // core clock rate
	localparam int unsigned TICK_MS      = 100;     // timing tick in ms
	localparam int unsigned TICK_CYCLES  = TICK_MS * CLK_MHZ * 1000;
	localparam int unsigned HOLD_MS      = 100;     // least flag time
	localparam int unsigned HOLD_TICKS   = (HOLD_MS + TICK_MS - 1) / TICK_MS;
	localparam int unsigned STOP_MS      = 3000;    // pinned-low time
	localparam int unsigned STOP_TICKS   = STOP_MS / TICK_MS;
	// units: level 0.1 %, factor 1 %, frequency 0.01 Hz, delay 0.1 s
	localparam logic [15:0] SENTINEL     = 16'h270F; // 9999
	localparam logic [15:0] FREQ_PIN_LOW = 16'h0064; // 1 Hz
	localparam logic [15:0] FREQ_DEC_TQ  = 16'h01F4; // 5 Hz
	localparam logic [31:0] FREQ_TOP     = 32'h00009C40; // 400 Hz
	localparam logic [15:0] PCT_100      = 16'h0064; // 100 %
	// function codes
	localparam logic [7:0]  FUNC_POS     = 8'h03;
	localparam logic [7:0]  FUNC_NEG     = 8'h67;    // 103
	localparam logic [7:0]  SEL_SPLIT    = 8'h64;    // 100
	localparam logic [7:0]  SEL_SPLIT_NF = 8'h65;    // 101
	// byte addresses
	localparam logic [7:0] A_CTRL       = 8'h00;
	localparam logic [7:0] A_BASE_LVL   = 8'h04;
	localparam logic [7:0] A_HS_FACTOR  = 8'h08;
	localparam logic [7:0] A_SECOND_LVL = 8'h0C;
	localparam logic [7:0] A_RED_START  = 8'h10;
	localparam logic [7:0] A_ACTION_SEL = 8'h14;
	localparam logic [7:0] A_FLAG_DELAY = 8'h18;
	localparam logic [7:0] A_MAX_FREQ   = 8'h1C;
	localparam logic [7:0] A_OUT_FUNC   = 8'h20;
	localparam logic [7:0] A_IN_FUNC    = 8'h24;
	localparam logic [7:0] A_STATUS     = 8'h28;
	localparam logic [7:0] A_IRQ_STAT   = 8'h2C;
	localparam logic [7:0] A_IRQ_MASK   = 8'h30;
	// reset values
	localparam logic [15:0] RST_BASE_LVL = 16'h05DC; // 150.0 %
	localparam logic [15:0] RST_RED_START = 16'h1770; // 60 Hz
	localparam logic [15:0] RST_MAX_FREQ = 16'h2EE0; // 120 Hz
	// field positions
	localparam int unsigned CTRL_TORQUE  = 0;
	localparam int unsigned CTRL_FCLR    = 1;
	localparam int unsigned IRQ_FLAG     = 0;
	localparam int unsigned IRQ_FAULT    = 1;
	// bus answers
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	typedef enum logic [0:0] {
		RD_IDLE  = 1'b0,
		RD_VALID = 1'b1
	} rd_state_e;
endpackage

//--- include/stall_level_if.sv
// carrier between the supervisor and its level calculator
`timescale 1ns/10ps
interface stall_level_if;
	logic [15:0] base_level;   // selected level L, 0.1 %
	logic [15:0] factor;       // compensation K, %
	logic [15:0] start_freq;   // reduction start, 0.01 Hz
	logic [15:0] out_freq;     // present output frequency
	logic [15:0] level;        // resulting level, registered
	modport calc (input base_level, factor, start_freq, out_freq,
		output level);
	modport user (output base_level, factor, start_freq, out_freq,
		input level);
endinterface

//--- hdl/stall_level_calc.sv
// high-frequency reduction of the stall level
`timescale 1ns/10ps
module stall_level_calc (
	input  wire logic  i_core_clk,
	input  wire logic  i_rst,
	stall_level_if.calc lif
);
	typedef struct packed {
		logic [15:0] level;   // registered result
	} calc_s;
	calc_s q;
	calc_s next_q;
	logic signed [63:0] l_v;  // base level widened
	logic signed [63:0] a_v;  // A term
	logic signed [63:0] b_v;  // B term
	logic signed [63:0] num;  // numerator of the correction
	logic signed [63:0] den;  // denominator of the correction
	logic signed [63:0] res;  // unclamped result

	// divisions are combinational; one cycle of latency is harmless
	// against a 100ms time base
	always_comb begin
		l_v = 64'(lif.base_level);
		a_v = 64'sh0;
		b_v = 64'sh0;
		num = 64'sh0;
		den = 64'sh0;
		res = l_v;
		next_q.level = lif.base_level;
		if (lif.factor != stall_pkg::SENTINEL &&
			lif.out_freq > lif.start_freq) begin
			a_v = (64'(lif.start_freq) * l_v) / 64'(lif.out_freq);
			b_v = (64'(lif.start_freq) * l_v) / 64'(stall_pkg::FREQ_TOP);
			num = b_v * (l_v - a_v) *
				(64'(lif.factor) - 64'(stall_pkg::PCT_100));
			den = (l_v - b_v) * 64'(stall_pkg::PCT_100);
			if (den > 64'sh0) begin
				res = a_v + num / den;
			end
			// clamp into 0..L, reduction never raises the level
			if (res < 64'sh0) begin
				next_q.level = 16'h0000;
			end else if (res > l_v) begin
				next_q.level = lif.base_level;
			end else begin
				next_q.level = res[15:0];
			end
		end
	end

	// result register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign lif.level = q.level;
endmodule // stall_level_calc

//--- test/stall_prevention_supervisor_properties.sv
// port checker of the stall supervisor, bound to its top module
`timescale 1ns/10ps
module stall_checker (
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	input wire logic        i_awvalid,
	input wire logic        o_awready,
	input wire logic        i_wvalid,
	input wire logic        o_wready,
	input wire logic [1:0]  o_bresp,
	input wire logic        o_bvalid,
	input wire logic        i_bready,
	input wire logic        i_arvalid,
	input wire logic        o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic        o_rvalid,
	input wire logic        i_rready,
	input wire logic        i_regen,
	input wire logic        o_stall_engage,
	input wire logic        o_freq_raise,
	input wire logic        o_stall_active_flag,
	input wire logic        o_stall_stop_fault,
	input wire logic        o_output_shutoff
);
	// a single clock domain, so clock and reset are stated once
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// answers must come in time and stand until the master takes them
	AST_B_HOLD: assert property (o_bvalid && !i_bready |=>
		o_bvalid && $stable(o_bresp)) else $error("write answer lost");
	AST_R_HOLD: assert property (o_rvalid && !i_rready |=>
		o_rvalid && $stable(o_rdata)) else $error("read answer lost");
	AST_AR_ANS: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read answer late");
	AST_B_ANS: assert property (i_awvalid && o_awready && i_wvalid &&
		o_wready |-> ##[1:3] o_bvalid) else $error("write answer late");
	// a raised flag stays up for at least eight cycles
	AST_FLAG_HOLD: assert property (
		$rose(o_stall_active_flag) |-> o_stall_active_flag [*8])
		else $error("flag too short");
	AST_FLAG_FALL: assert property (
		$fell(o_stall_active_flag) |-> !$past(o_stall_engage))
		else $error("flag fell while engaged");
	AST_RAISE: assert property (
		$rose(o_freq_raise) |-> $past(i_regen))
		else $error("raise outside regeneration");
	AST_FAULT_OFF: assert property (
		$rose(o_stall_stop_fault) |-> ##[0:1] o_output_shutoff
		&& $past(o_stall_engage || o_stall_active_flag))
		else $error("fault without cause or shutoff");
endmodule // stall_checker
bind stall_prevention_supervisor stall_checker chk (.*);

//--- test/stall_drive_model.sv
// frequency controller and current sensor beyond the supervisor
`timescale 1ns/10ps
module stall_drive_model (
	input  wire logic        i_core_clk,
	input  wire logic [15:0] i_set_current, // load asked for by bench
	input  wire logic [15:0] i_set_torque,
	input  wire logic [15:0] i_set_freq,
	input  wire logic        i_stall_engage,
	input  wire logic        i_output_shutoff,
	output logic      [15:0] o_out_current,
	output logic      [15:0] o_torque_current,
	output logic      [15:0] o_out_freq
);
	logic [15:0] freq = 16'h0000; // present output frequency
	// a tripped drive carries no current at all
	assign o_out_current = i_output_shutoff ? 16'h0000 : i_set_current;
	assign o_torque_current = i_output_shutoff ? 16'h0000 : i_set_torque;
	assign o_out_freq = freq;
	// stall action pulls frequency down, floored at 1 Hz like a real loop
	always_ff @(posedge i_core_clk) begin
		if (i_output_shutoff)
			freq <= 16'h0000;
		else if (!i_stall_engage)
			freq <= i_set_freq;
		else
			freq <= (freq > 16'h00C8) ? freq - 16'h0064 : 16'h0064;
	end
endmodule // stall_drive_model

//--- test/stall_prevention_supervisor_tb.sv
// self-checking bench of the stall supervisor
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
	$display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module stall_prevention_supervisor_tb;
	localparam int unsigned TICK = 20; // short tick keeps the run brief
	logic        i_core_clk = '0, i_rst = 1'h1;
	logic [7:0]  i_awaddr = '0, i_araddr = '0;
	logic [31:0] i_wdata = '0, o_rdata, d;
	logic [3:0]  i_wstrb = 4'hF, i_virtual_in = '0;
	logic        i_awvalid = '0, i_wvalid = '0, i_bready = '0;
	logic        i_arvalid = '0, i_rready = '0;
	logic        i_accel = '0, i_const_speed = '0, i_decel = '0;
	logic        i_regen = '0, i_fast_limit_hit = '0;
	logic        i_regen_avoid = '0, i_ov_stall = '0;
	logic [15:0] cur = '0, tq = '0, fset = 16'h07D0; // load and speed
	logic [15:0] i_out_current, i_torque_current, i_out_freq;
	logic [15:0] o_freq_ceiling;
	logic [1:0]  o_bresp, o_rresp, o_virtual_out, r;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic        o_stall_engage, o_fast_limit_enable, o_freq_raise;
	logic        o_stall_active_flag, o_open_collector_output;
	logic        o_stall_stop_fault, o_output_shutoff, o_irq;
	int          num_errors = 0, compares = 0;
	initial forever #4 i_core_clk = ~i_core_clk;
	stall_prevention_supervisor #(.TICK_CYCLES(TICK)) dut (.*);
	stall_drive_model model (
		.i_core_clk      (i_core_clk),
		.i_set_current   (cur),
		.i_set_torque    (tq),
		.i_set_freq      (fset),
		.i_stall_engage  (o_stall_engage),
		.i_output_shutoff(o_output_shutoff),
		.o_out_current   (i_out_current),
		.o_torque_current(i_torque_current),
		.o_out_freq      (i_out_freq)
	);
	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask
	// reset and quiet drive; every scenario starts from here
	task automatic rs();
		@(posedge i_core_clk);
		i_rst <= 1'h1;
		{i_accel, i_const_speed, i_decel, i_regen} <= '0;
		{i_fast_limit_hit, i_regen_avoid, i_ov_stall} <= '0;
		{i_virtual_in, cur, tq} <= '0;
		fset <= 16'h07D0;
		cyc(6);
		i_rst <= 1'h0;
	endtask
	// ready to answer is raised late so a waiting answer gets seen
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_core_clk);
		{i_awaddr, i_wdata, i_awvalid, i_wvalid} <= {a, v, 2'h3};
		do begin
			@(posedge i_core_clk);
			if (o_awready) i_awvalid <= 1'h0;
			if (o_wready) i_wvalid <= 1'h0;
			if (!i_awvalid && !i_wvalid) i_bready <= 1'h1;
		end while (!(o_bvalid === 1'h1 && i_bready));
		r = o_bresp;
		i_bready <= 1'h0;
		cyc(1); // outputs follow a new setting one cycle late
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_core_clk);
		{i_araddr, i_arvalid} <= {a, 1'h1};
		do begin
			@(posedge i_core_clk);
			if (o_arready) i_arvalid <= 1'h0;
			if (!i_arvalid) i_rready <= 1'h1;
		end while (!(o_rvalid === 1'h1 && i_rready));
		{d, r} = {o_rdata, o_rresp};
		i_rready <= 1'h0;
	endtask
	// level at 300 Hz: constant, then A = 6000*1500/30000 = 300
	task automatic t_level();
		rs();
		fset <= 16'h7530;
		rd(stall_pkg::A_STATUS);
		`CHK(d[31:16], 16'h05DC)
		wr(stall_pkg::A_HS_FACTOR, 32'h00000064);
		rd(stall_pkg::A_STATUS);
		`CHK(d[31:16], 16'h012C)
		`CHK(o_freq_ceiling, 16'h2EE0)
		wr(8'h40, 32'h00000001);
		`CHK(r, stall_pkg::RESP_SLVERR)
		rd(8'h44);
		`CHK(r, stall_pkg::RESP_SLVERR)
	endtask
	task automatic t_flag();
		rs();
		wr(stall_pkg::A_OUT_FUNC, 32'h00030303);
		wr(stall_pkg::A_IRQ_MASK, 32'h00000001);
		{i_accel, cur} <= {1'h1, 16'h0640};
		cyc(6);
		`CHK({o_stall_active_flag, o_open_collector_output}, 2'h3)
		`CHK({o_virtual_out, o_irq}, 3'h7)
		cur <= 16'h0000;
		cyc(12);
		`CHK(o_stall_active_flag, 1'h1)
		cyc(50);
		`CHK(o_stall_active_flag, 1'h0)
		wr(stall_pkg::A_OUT_FUNC, 32'h00676767);
		`CHK({o_open_collector_output, o_virtual_out}, 3'h7)
		wr(stall_pkg::A_IRQ_STAT, 32'h00000001);
		`CHK(o_irq, 1'h0)
	endtask
	// delay 9999 never flags; delay 1.0 s flags on the eleventh tick
	task automatic t_delay();
		rs();
		wr(stall_pkg::A_FLAG_DELAY, 32'h0000270F);
		{i_accel, cur} <= {1'h1, 16'h0640};
		cyc(300);
		`CHK(o_stall_active_flag, 1'h0)
		rs();
		wr(stall_pkg::A_FLAG_DELAY, 32'h0000000A);
		{i_accel, cur} <= {1'h1, 16'h0640};
		cyc(150);
		`CHK(o_stall_active_flag, 1'h0)
		cyc(130);
		`CHK(o_stall_active_flag, 1'h1)
	endtask
	task automatic t_sel();
		rs();
		wr(stall_pkg::A_ACTION_SEL, 32'h00000001);
		`CHK(o_fast_limit_enable, 1'h0)
		wr(stall_pkg::A_ACTION_SEL, 32'h00000065);
		`CHK(o_fast_limit_enable, 1'h0)
		{i_regen, i_accel, cur} <= {2'h3, 16'h0640};
		wr(stall_pkg::A_ACTION_SEL, 32'h00000064);
		cyc(4);
		`CHK(o_stall_engage, 1'h0)
		i_regen <= 1'h0;
		// each state is refused by its own weight, then engages
		for (int k = 0; k < 3; k++) begin
			{i_decel, i_const_speed, i_accel} <= 3'h1 << k;
			wr(stall_pkg::A_ACTION_SEL, 32'h00000002 << k);
			cyc(4);
			`CHK(o_stall_engage, 1'h0)
			wr(stall_pkg::A_ACTION_SEL, 32'h00000000);
			cyc(4);
			`CHK(o_stall_engage, 1'h1)
		end
		{i_decel, cur, i_fast_limit_hit} <= {17'h00000, 1'h1};
		cyc(60);
		`CHK(o_stall_active_flag, 1'h0)
		for (int k = 0; k < 2; k++) begin
			{i_ov_stall, i_regen_avoid} <= 2'h1 << k;
			cyc(4);
			`CHK(o_stall_active_flag, 1'h1)
			{i_ov_stall, i_regen_avoid} <= 2'h0;
			cyc(60);
		end
	endtask
	task automatic t_second();
		rs();
		wr(stall_pkg::A_IN_FUNC, 32'h00000003);
		wr(stall_pkg::A_SECOND_LVL, 32'h000001F4);
		{i_const_speed, cur} <= {1'h1, 16'h03E8};
		cyc(4);
		`CHK(o_stall_engage, 1'h0)
		i_virtual_in <= 4'h1;
		cyc(4);
		`CHK(o_stall_engage, 1'h1)
		rs();
		wr(stall_pkg::A_CTRL, 32'h00000001);
		{i_decel, tq, fset} <= {1'h1, 16'h0640, 16'h0190};
		cyc(4);
		`CHK(o_stall_engage, 1'h0)
		{i_decel, i_const_speed, i_regen} <= 3'h3;
		fset <= 16'h07D0;
		cyc(4);
		`CHK({o_stall_engage, o_freq_raise}, 2'h3)
	endtask
	task automatic t_stop();
		rs();
		wr(stall_pkg::A_ACTION_SEL, 32'h00000010);
		wr(stall_pkg::A_IRQ_MASK, 32'h00000002);
		{i_accel, cur} <= {1'h1, 16'h0640};
		cyc(8);
		`CHK({o_stall_stop_fault, o_output_shutoff}, 2'h3)
		`CHK(o_irq, 1'h1)
		cur <= 16'h0000;
		cyc(50); // a still held flag would trip the stop option again
		wr(stall_pkg::A_CTRL, 32'h00000002);
		wr(stall_pkg::A_IRQ_STAT, 32'h00000002);
		`CHK({o_stall_stop_fault, o_irq}, 2'h0)
		rs();
		{i_accel, cur} <= {1'h1, 16'h0640};
		cyc(500);
		`CHK(o_stall_stop_fault, 1'h0)
		cyc(200);
		`CHK({o_stall_stop_fault, o_output_shutoff}, 2'h3)
	endtask
	task automatic print_verdict();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		t_level();
		t_flag();
		t_delay();
		t_sel();
		t_second();
		t_stop();
		print_verdict();
	end
	// watchdog: the scenarios need well under a fifth of this span
	initial begin
		#400000;
		num_errors++;
		print_verdict();
	end
endmodule // stall_prevention_supervisor_tb
